//--- core/fsg_guard.sv
// Top: flash self-program guard with Avalon-MM register slave
//
// Function
// R1 - Programming concurrent-read region keeps CPU running; halting region stays readable.
// R2 - Programming the halting region halts the CPU for the whole operation.
// R3 - Operation class comes from the target address, not the executing address.
// R4 - Software never fetches or reads the concurrent-read region while programmed.
// R5 - Software should disable interrupts or move vectors to boot region.
// R6 - Boot region always lies inside the halting region for every boot size.
// R7 - Busy flag reads one while the concurrent-read region is blocked.
// R8 - Software clears busy flag before using concurrent-read region code.
// R9 - Lock fields set by software or programming port; only chip erase clears; reset also returns both fields to 11.
// R10 - General memory lock modes do not gate self-programming accesses.
// R11 - Application lock 11 unrestricted; 10 blocks writes to application region.
// R12 - Application lock 00 blocks writes and boot-executed reads of application.
// R13 - Application lock 01 blocks boot-executed reads only.
// R14 - Application modes 3,4 with boot vectors disable interrupts in application.
// R15 - Boot lock 11 unrestricted; 10 blocks writes to boot region.
// R16 - Boot lock 00 blocks writes and application-executed reads of boot region.
// R17 - Boot lock 01 blocks application-executed reads of boot, writes allowed.
// R18 - Boot modes 3,4 with application vectors disable interrupts in boot region.
// R19 - Lock bit one means unprogrammed, zero means programmed.
// R20 - Store-program erase or write only accepted from the boot region.
// R21 - Busy flag set when concurrent-read region erase or write begins.
// R22 - Busy cleared by read-reenable after completion or by buffer load.
// R23 - A blocked access leaves flash contents and protected region untouched.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module fsg_guard
   import fsg_pkg::*;
#(
   parameter int            AW          = 14,
   parameter logic [AW-1:0] HALT_BASE   = 14'h3000,
   parameter int            BOOT_MIN_W  = 256,
   parameter int            PROG_CYCLES = 100
) (
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire logic [3:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output      logic [31:0]   avs_readdata,
   output      logic          avs_waitrequest,
   input  wire logic [1:0]    boot_size_fuses,
   input  wire logic [AW-1:0] exec_pc,
   input  wire logic          spm_req,
   input  wire logic [2:0]    spm_cmd,
   input  wire logic [AW-1:0] spm_addr,
   input  wire logic [3:0]    spm_lock_data,
   input  wire logic          lpm_req,
   input  wire logic [AW-1:0] lpm_addr,
   output      logic          lpm_grant,
   output      logic          lpm_deny,
   output      logic          cpu_halt,
   output      logic          region_busy_flag,
   output      logic          fetch_block,
   output      logic          int_disable,
   output      logic          flash_buf_load,
   output      logic          flash_erase,
   output      logic          flash_write,
   output      logic [AW-1:0] flash_page
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   localparam int FLASH_W = 1 << AW;
   localparam int CW      = $clog2(PROG_CYCLES + 1);
   initial begin
      // Largest boot size must still fit above the halting base [R6]
      if (BOOT_MIN_W * 8 > FLASH_W - int'(HALT_BASE))
         $error("boot region can exceed halting region");
      if (PROG_CYCLES < 1 || AW < 4)
         $error("unsupported parameter value");
   end
   localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fsg_state_t    state_r;
   logic [CW-1:0] cnt_r;
   logic [1:0]    app_lock_r;
   logic [1:0]    boot_lock_r;
   logic          vec_boot_r;
   logic          busy_r;
   logic          halt_r;
   logic          fetch_block_r;
   logic          int_dis_r;
   logic          lpm_grant_r;
   logic          lpm_deny_r;
   logic          buf_load_r;
   logic          erase_r;
   logic          write_r;
   logic [AW-1:0] page_r;
   logic          wait_r;
   logic [31:0]   rdata_r;
   logic [AW-1:0] boot_base;

   // Boot size code 11 is the smallest region; it doubles per step down
   assign boot_base = AW'(FLASH_W - (BOOT_MIN_W << (2'h3 - boot_size_fuses)));

   // ------------------------------------------------------------
   // Region lookup and lock checks
   // ------------------------------------------------------------
   fsg_reg_if #(.AW(AW)) tgt_rg ();
   fsg_reg_if #(.AW(AW)) exe_rg ();
   fsg_reg_if #(.AW(AW)) lpm_rg ();
   fsg_lck_if spm_lk ();
   fsg_lck_if lpm_lk ();

   assign tgt_rg.addr      = spm_addr;
   assign tgt_rg.boot_base = boot_base;
   assign exe_rg.addr      = exec_pc;
   assign exe_rg.boot_base = boot_base;
   assign lpm_rg.addr      = lpm_addr;
   assign lpm_rg.boot_base = boot_base;

   fsg_region_decode #(.AW(AW), .HALT_BASE(HALT_BASE)) u_tgt (.r(tgt_rg));
   fsg_region_decode #(.AW(AW), .HALT_BASE(HALT_BASE)) u_exe (.r(exe_rg));
   fsg_region_decode #(.AW(AW), .HALT_BASE(HALT_BASE)) u_lpm (.r(lpm_rg));

   assign spm_lk.app_lock  = app_lock_r;
   assign spm_lk.boot_lock = boot_lock_r;
   assign spm_lk.tgt_boot  = tgt_rg.in_boot;
   assign spm_lk.exec_boot = exe_rg.in_boot;
   assign spm_lk.vec_boot  = vec_boot_r;
   assign lpm_lk.app_lock  = app_lock_r;
   assign lpm_lk.boot_lock = boot_lock_r;
   assign lpm_lk.tgt_boot  = lpm_rg.in_boot;
   assign lpm_lk.exec_boot = exe_rg.in_boot;
   assign lpm_lk.vec_boot  = vec_boot_r;

   fsg_lock_check u_spm_chk (.l(spm_lk));
   fsg_lock_check u_lpm_chk (.l(lpm_lk));

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   logic idle;
   logic spm_take;
   logic prog_cmd;
   logic start_ok;
   logic done;
   assign idle     = (state_r == FSG_IDLE);
   // Store-program from the application region is ignored outright [R20]
   assign spm_take = spm_req && exe_rg.in_boot && idle;
   assign prog_cmd = (spm_cmd == CMD_ERASE) || (spm_cmd == CMD_WRITE);
   // Locked targets are refused before the flash sees anything [R23]
   assign start_ok = spm_take && prog_cmd && spm_lk.wr_ok;
   assign done     = (state_r == FSG_PROG) && (cnt_r == PROG_LAST);

   // ------------------------------------------------------------
   // Avalon-MM slave: one wait state, write lands on the release edge
   // ------------------------------------------------------------
   logic bus_req;
   logic wr_hit;
   logic chip_erase;
   assign bus_req    = avs_read || avs_write;
   assign wr_hit     = avs_write && !wait_r;
   assign chip_erase = wr_hit && (avs_address == REG_CTRL)
                       && avs_writedata[CT_CHIP_ERS];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !(bus_req && wait_r);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= RD_ZERO;
      end else if (avs_read && wait_r) begin
         case (avs_address)
            REG_STATUS: rdata_r <= {24'h0, boot_lock_r, app_lock_r, int_dis_r,
                                    halt_r, !idle, busy_r};
            REG_LOCK:   rdata_r <= {28'h0, boot_lock_r, app_lock_r};
            REG_CTRL:   rdata_r <= {31'h0, vec_boot_r};
            default:    rdata_r <= RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vec_boot_r <= 1'b0;
      end else if (wr_hit && avs_address == REG_CTRL) begin
         vec_boot_r <= avs_writedata[CT_VEC_BOOT];
      end
   end

   // ------------------------------------------------------------
   // Lock fields: both paths may only program bits, chip erase clears
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         app_lock_r  <= LOCK_UNPROG;
         boot_lock_r <= LOCK_UNPROG;
      end else if (chip_erase) begin
         app_lock_r  <= LOCK_UNPROG; // [R9]
         boot_lock_r <= LOCK_UNPROG;
      end else begin
         if (wr_hit && avs_address == REG_LOCK) begin
            app_lock_r  <= app_lock_r & avs_writedata[LK_APP_LO +: 2]; // [R9][R19]
            boot_lock_r <= boot_lock_r & avs_writedata[LK_BOOT_LO +: 2];
         end else if (spm_take && spm_cmd == CMD_LOCK_SET) begin
            app_lock_r  <= app_lock_r & spm_lock_data[LK_APP_LO +: 2]; // [R9][R19]
            boot_lock_r <= boot_lock_r & spm_lock_data[LK_BOOT_LO +: 2];
         end
      end
   end

   // ------------------------------------------------------------
   // Programming sequencer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= FSG_IDLE;
         cnt_r   <= '0;
         page_r  <= '0;
      end else begin
         case (state_r)
            FSG_IDLE: begin
               if (start_ok) begin
                  state_r <= FSG_PROG;
                  cnt_r   <= '0;
                  page_r  <= spm_addr;
               end
            end
            FSG_PROG: begin
               if (done) begin
                  state_r <= FSG_IDLE;
               end
               cnt_r <= cnt_r + 1'b1;
            end
            default: state_r <= FSG_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         erase_r    <= 1'b0;
         write_r    <= 1'b0;
         buf_load_r <= 1'b0;
      end else begin
         erase_r    <= start_ok && spm_cmd == CMD_ERASE;
         write_r    <= start_ok && spm_cmd == CMD_WRITE;
         buf_load_r <= spm_take && spm_cmd == CMD_BUF_LOAD;
      end
   end

   // Halt only when the target lies in the halting region [R2][R3]
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         halt_r <= 1'b0;
      end else if (start_ok) begin
         halt_r <= tgt_rg.in_halt; // [R1]
      end else if (done) begin
         halt_r <= 1'b0;
      end
   end

   // Busy stays up after completion until software reenables or loads the buffer [R8]
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_r <= 1'b0;
      end else if (start_ok && !tgt_rg.in_halt) begin
         busy_r <= 1'b1; // [R21]
      end else if (spm_take && (spm_cmd == CMD_REENABLE || spm_cmd == CMD_BUF_LOAD)) begin
         busy_r <= 1'b0; // [R22]
      end
   end

   // ------------------------------------------------------------
   // Read gating and interrupt gating
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lpm_grant_r   <= 1'b0;
         lpm_deny_r    <= 1'b0;
         fetch_block_r <= 1'b0;
         int_dis_r     <= 1'b0;
      end else begin
         // Reads into the busy region are refused rather than returning junk [R7][R4]
         lpm_grant_r   <= lpm_req && lpm_lk.rd_ok && !(busy_r && !lpm_rg.in_halt);
         lpm_deny_r    <= lpm_req && !(lpm_lk.rd_ok && !(busy_r && !lpm_rg.in_halt));
         fetch_block_r <= busy_r && !exe_rg.in_halt; // [R7]
         int_dis_r     <= spm_lk.int_dis; // [R14][R18]
      end
   end

   assign avs_readdata     = rdata_r;
   assign avs_waitrequest  = wait_r;
   assign lpm_grant        = lpm_grant_r;
   assign lpm_deny         = lpm_deny_r;
   assign cpu_halt         = halt_r;
   assign region_busy_flag = busy_r;
   assign fetch_block      = fetch_block_r;
   assign int_disable      = int_dis_r;
   assign flash_buf_load   = buf_load_r;
   assign flash_erase      = erase_r;
   assign flash_write      = write_r;
   assign flash_page       = page_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_start_halt;
      start_ok && tgt_rg.in_halt;
   endsequence
   sequence s_start_conc;
      start_ok && !tgt_rg.in_halt;
   endsequence

   chk_halt_on_start: assert property (s_start_halt |=> halt_r && !idle) // [R2]
      else $error("halting-region op did not halt CPU");
   chk_halt_whole_op: assert property (halt_r |-> !idle) // [R2]
      else $error("CPU halted outside an operation");
   chk_conc_no_halt: assert property (s_start_conc |=> !halt_r && busy_r) // [R1][R21]
      else $error("concurrent-region op halted CPU or left busy low");
   chk_app_spm_ignored: assert property (spm_req && !exe_rg.in_boot |=> !erase_r && !write_r) // [R20]
      else $error("store-program from application region took effect");
   chk_locked_write: assert property (spm_take && prog_cmd && !spm_lk.wr_ok
      |=> !erase_r && !write_r && idle) // [R11][R15][R23]
      else $error("write to locked region started");
   chk_busy_lpm: assert property (lpm_req && busy_r && !lpm_rg.in_halt
      |=> lpm_deny_r && !lpm_grant_r) // [R7]
      else $error("read of busy region granted");
   chk_cross_read: assert property (lpm_req && !lpm_rg.in_boot && exe_rg.in_boot
      && !app_lock_r[LOCK_HI] |=> lpm_deny_r) // [R12][R13]
      else $error("boot code read locked application region");
   chk_boot_read: assert property (lpm_req && lpm_rg.in_boot && !exe_rg.in_boot
      && !boot_lock_r[LOCK_HI] |=> lpm_deny_r) // [R16][R17]
      else $error("application code read locked boot region");
   chk_lock_monotone: assert property (((app_lock_r & ~$past(app_lock_r)) != 2'h0)
      |-> $past(chip_erase)) // [R9][R19]
      else $error("lock bit unprogrammed without chip erase");
   chk_busy_clear: assert property (spm_take && spm_cmd == CMD_REENABLE
      |=> !busy_r) // [R22]
      else $error("reenable did not clear busy flag");
   chk_prog_len: assert property (s_start_halt |=> halt_r [*2] ##[0:1000] !halt_r) // [R2]
      else $error("halt too short or too long");
   chk_boot_in_halt: assert property (boot_base >= HALT_BASE) // [R6]
      else $error("boot region outside halting region");
   chk_int_gate: assert property (!exe_rg.in_boot && !app_lock_r[LOCK_HI] && vec_boot_r
      |=> int_dis_r) // [R14]
      else $error("interrupts not disabled in application region");
endmodule

//--- core/fsg_pkg.sv
// Package: constants for the flash self-program guard
package fsg_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_LOCK   = 4'h4;
   localparam logic [3:0] REG_CTRL   = 4'h8;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ST_BUSY     = 0;
   localparam int ST_ACTIVE   = 1;
   localparam int ST_HALT     = 2;
   localparam int ST_INTDIS   = 3;
   localparam int ST_APP_LO   = 4;
   localparam int ST_BOOT_LO  = 6;
   localparam int LK_APP_LO   = 0;
   localparam int LK_BOOT_LO  = 2;
   localparam int CT_VEC_BOOT = 0;
   localparam int CT_CHIP_ERS = 1;
   localparam int LOCK_HI     = 1;
   localparam int LOCK_LO     = 0;
   // ------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------
   localparam logic [1:0]  LOCK_UNPROG = 2'h3;
   localparam logic [31:0] RD_ZERO     = 32'h0;
   localparam logic [2:0]  CMD_BUF_LOAD = 3'h0;
   localparam logic [2:0]  CMD_ERASE    = 3'h1;
   localparam logic [2:0]  CMD_WRITE    = 3'h2;
   localparam logic [2:0]  CMD_LOCK_SET = 3'h3;
   localparam logic [2:0]  CMD_REENABLE = 3'h4;
   typedef enum logic [1:0] {FSG_IDLE, FSG_PROG} fsg_state_t;
endpackage

//--- core/fsg_if.sv
// Interfaces: region lookup and lock check carriers
`timescale 1ns/1ns
interface fsg_reg_if #(parameter int AW = 14);
   logic [AW-1:0] addr;
   logic [AW-1:0] boot_base;
   logic          in_boot;
   logic          in_halt;
   modport dec (input addr, input boot_base, output in_boot, output in_halt);
   modport usr (output addr, output boot_base, input in_boot, input in_halt);
endinterface

interface fsg_lck_if;
   logic [1:0] app_lock;
   logic [1:0] boot_lock;
   logic       tgt_boot;
   logic       exec_boot;
   logic       vec_boot;
   logic       wr_ok;
   logic       rd_ok;
   logic       int_dis;
   modport chk (input app_lock, input boot_lock, input tgt_boot, input exec_boot,
                input vec_boot, output wr_ok, output rd_ok, output int_dis);
   modport usr (output app_lock, output boot_lock, output tgt_boot, output exec_boot,
                output vec_boot, input wr_ok, input rd_ok, input int_dis);
endinterface

//--- core/fsg_region_decode.sv
// Region decode: places an address in the boot and halting regions
`timescale 1ns/1ns
module fsg_region_decode #(
   parameter int            AW        = 14,
   parameter logic [AW-1:0] HALT_BASE = 14'h3000
) (
   fsg_reg_if.dec r
);
   // Classification is by the address handed in, never by who asks [R3]
   assign r.in_halt = (r.addr >= HALT_BASE);
   assign r.in_boot = (r.addr >= r.boot_base);
endmodule

//--- core/fsg_lock_check.sv
// Lock check: write, cross-region read and interrupt gating
`timescale 1ns/1ns
module fsg_lock_check
   import fsg_pkg::*;
(
   fsg_lck_if.chk l
);
   logic [1:0] tgt_lock;
   // Only the two region fields decide; general memory locks are not inputs [R10]
   assign tgt_lock = l.tgt_boot ? l.boot_lock : l.app_lock;
   // Low bit zero (modes 2 and 3) forbids writes; zero means programmed [R11][R12][R15][R16][R19]
   assign l.wr_ok = tgt_lock[LOCK_LO];
   // High bit zero (modes 3 and 4) forbids reads from the other region [R12][R13][R16][R17]
   assign l.rd_ok = (l.tgt_boot == l.exec_boot) || tgt_lock[LOCK_HI];
   // Vectors held in the locked-off region must not be taken [R14][R18]
   assign l.int_dis = l.exec_boot ? (!l.boot_lock[LOCK_HI] && !l.vec_boot)
                                  : (!l.app_lock[LOCK_HI] && l.vec_boot);
endmodule

//--- tb/fsg_cpu_model.sv
// Partner: CPU core model issuing store-program and load-program operations
`timescale 1ns/1ns
module fsg_cpu_model
   import fsg_pkg::*;
#(
   parameter logic [13:0] HALT_BASE = 14'h3000
) (
   input  wire logic        sys_clk,
   input  wire logic        cpu_halt,
   input  wire logic        region_busy_flag,
   input  wire logic        lpm_grant,
   input  wire logic        lpm_deny,
   output      logic [13:0] exec_pc,
   output      logic        spm_req,
   output      logic [2:0]  spm_cmd,
   output      logic [13:0] spm_addr,
   output      logic [3:0]  spm_lock_data,
   output      logic        lpm_req,
   output      logic [13:0] lpm_addr
);
   // No interrupt source here, so nothing can vector into a busy region
   logic break_order;
   initial begin
      break_order = 1'h0;
      {exec_pc, spm_req, spm_cmd, spm_addr, spm_lock_data} = {14'h3F10, 22'h0};
      {lpm_req, lpm_addr} = 15'h0;
   end
   task automatic goto(input logic [13:0] pc);
      @(posedge sys_clk);
      exec_pc <= pc;
   endtask
   // A halted core cannot issue a store-program operation until it is released
   task automatic spm_op(input logic [2:0] cmd, input logic [13:0] a, input logic [3:0] ld);
      @(posedge sys_clk);
      while (cpu_halt === 1'h1) @(posedge sys_clk);
      {spm_req, spm_cmd, spm_addr, spm_lock_data} <= {1'h1, cmd, a, ld};
      @(posedge sys_clk);
      spm_req <= 1'h0;
      spm_addr <= ~a;
   endtask
   // Unless told to misbehave, the core re-enables the busy region before reading it
   task automatic lpm_op(input logic [13:0] a, output logic [1:0] gd);
      if (!break_order && region_busy_flag === 1'h1 && a < HALT_BASE) begin
         spm_op(CMD_REENABLE, a, 4'hF);
      end
      @(posedge sys_clk);
      {lpm_req, lpm_addr} <= {1'h1, a};
      @(posedge sys_clk);
      {lpm_req, lpm_addr} <= {1'h0, ~a};
      #1 gd = {lpm_grant, lpm_deny};
   endtask
endmodule

//--- tb/tb_top.sv
// Testbench: self-checking bench for the flash self-program guard
`timescale 1ns/1ns
module tb_top;
   import fsg_pkg::*;
   localparam int          PC  = 8;
   localparam logic [13:0] BPC = 14'h3F10;
   localparam logic [13:0] APC = 14'h0100;
   localparam logic [13:0] AAD = 14'h0200;
   localparam logic [13:0] BAD = 14'h3F80;
   typedef struct packed {
      logic [1:0]  app;
      logic [1:0]  boot;
      logic        vec;
      logic [13:0] pc;
      logic [13:0] ad;
      logic [1:0]  gd;
      logic        intd;
   } fsg_row_t;
   logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address, spm_lock_data;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0]  boot_size_fuses, gd;
   logic [13:0] exec_pc, spm_addr, lpm_addr, flash_page;
   logic [2:0]  spm_cmd;
   logic        spm_req, lpm_req, lpm_grant, lpm_deny, cpu_halt, region_busy_flag;
   logic        fetch_block, int_disable, flash_buf_load, flash_erase, flash_write;
   int          miscompares, check_count, cycles, n;
   fsg_row_t    rows [7] = '{
      '{2'h3, 2'h3, 1'h0, BPC, AAD, 2'h2, 1'h0},
      '{2'h1, 2'h3, 1'h1, BPC, AAD, 2'h1, 1'h0},
      '{2'h0, 2'h3, 1'h1, APC, AAD, 2'h2, 1'h1},
      '{2'h3, 2'h0, 1'h0, APC, BAD, 2'h1, 1'h0},
      '{2'h3, 2'h1, 1'h0, BPC, BAD, 2'h2, 1'h1},
      '{2'h2, 2'h2, 1'h1, APC, BAD, 2'h2, 1'h0},
      '{2'h0, 2'h3, 1'h1, BPC, AAD, 2'h1, 1'h0}
   };
   fsg_guard #(.PROG_CYCLES(PC)) i_fsg_guard (
      .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .boot_size_fuses(boot_size_fuses),
      .exec_pc(exec_pc), .spm_req(spm_req), .spm_cmd(spm_cmd), .spm_addr(spm_addr),
      .spm_lock_data(spm_lock_data), .lpm_req(lpm_req), .lpm_addr(lpm_addr),
      .lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .cpu_halt(cpu_halt),
      .region_busy_flag(region_busy_flag), .fetch_block(fetch_block),
      .int_disable(int_disable), .flash_buf_load(flash_buf_load),
      .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page));
   fsg_cpu_model i_fsg_cpu_model (
      .sys_clk(sys_clk), .cpu_halt(cpu_halt), .region_busy_flag(region_busy_flag),
      .lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .exec_pc(exec_pc), .spm_req(spm_req),
      .spm_cmd(spm_cmd), .spm_addr(spm_addr), .spm_lock_data(spm_lock_data),
      .lpm_req(lpm_req), .lpm_addr(lpm_addr));
   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial sys_clk = 1'h0;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request holds until waitrequest is sampled low; a silent slave counts as a fault
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
      k = 0;
      do begin @(posedge sys_clk); k++; end while (avs_waitrequest !== 1'h0 && k < 50);
      q = avs_readdata;
      {avs_read, avs_write} <= 2'h0;
      if (k == 50) miscompares++;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      check(q, e);
   endtask
   task automatic setlk(input logic [1:0] app, input logic [1:0] boot, input logic vec);
      bus(1'h1, REG_CTRL, {30'h0, 1'h1, vec});
      bus(1'h1, REG_LOCK, {28'h0, boot, app});
   endtask
   task automatic wait_idle();
      n = 0;
      do begin bus(1'h0, REG_STATUS, 32'h0); n++; end while (q[ST_ACTIVE] !== 1'h0 && n < 40);
   endtask
   task automatic halt_len();
      n = 1;
      while (cpu_halt === 1'h1 && n < 40) begin @(posedge sys_clk); #1; n++; end
      check(n == PC + 1 || n == PC + 2, 1);
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      boot_size_fuses = 2'h3;
      reset_n = 1'h0;
      repeat (4) @(posedge sys_clk);
      check(avs_waitrequest, 1);
      reset_n <= 1'h1;
      rd(REG_STATUS, 32'hF0);
      rd(REG_LOCK, 32'hF);
      bus(1'h1, REG_STATUS, 32'hFF);
      bus(1'h1, 4'hC, 32'hFF);
      rd(REG_STATUS, 32'hF0);
      rd(4'hC, 32'h0);
      foreach (rows[i]) begin
         setlk(rows[i].app, rows[i].boot, rows[i].vec);
         i_fsg_cpu_model.goto(rows[i].pc);
         i_fsg_cpu_model.lpm_op(rows[i].ad, gd);
         check(gd, rows[i].gd);
         repeat (2) @(posedge sys_clk);
         #1 check(int_disable, rows[i].intd);
         rd(REG_STATUS, {24'h0, rows[i].boot, rows[i].app, rows[i].intd, 3'h0});
      end
      setlk(2'h3, 2'h3, 1'h0);
      i_fsg_cpu_model.goto(BPC);
      i_fsg_cpu_model.spm_op(CMD_ERASE, 14'h3040, 4'hF);
      #1 check({flash_erase, cpu_halt, region_busy_flag, flash_page}, {3'h6, 14'h3040});
      halt_len();
      i_fsg_cpu_model.spm_op(CMD_WRITE, AAD, 4'hF);
      #1 check({flash_write, cpu_halt, region_busy_flag}, 3'h5);
      i_fsg_cpu_model.lpm_op(14'h3100, gd);
      check(gd, 2'h2);
      i_fsg_cpu_model.break_order = 1'h1;
      i_fsg_cpu_model.lpm_op(AAD, gd);
      check(gd, 2'h1);
      i_fsg_cpu_model.goto(APC);
      repeat (2) @(posedge sys_clk);
      #1 check(fetch_block, 1);
      i_fsg_cpu_model.goto(BPC);
      wait_idle();
      check(q[ST_BUSY], 1);
      i_fsg_cpu_model.break_order = 1'h0;
      i_fsg_cpu_model.lpm_op(AAD, gd);
      check({gd, region_busy_flag}, 3'h4);
      i_fsg_cpu_model.spm_op(CMD_WRITE, AAD, 4'hF);
      wait_idle();
      i_fsg_cpu_model.spm_op(CMD_BUF_LOAD, AAD, 4'hF);
      #1 check({flash_buf_load, region_busy_flag}, 2'h2);
      i_fsg_cpu_model.goto(APC);
      i_fsg_cpu_model.spm_op(CMD_ERASE, 14'h3040, 4'hF);
      #1 check({flash_erase, cpu_halt}, 2'h0);
      i_fsg_cpu_model.goto(BPC);
      setlk(2'h2, 2'h2, 1'h0);
      i_fsg_cpu_model.spm_op(CMD_WRITE, AAD, 4'hF);
      #1 check({flash_write, region_busy_flag}, 2'h0);
      i_fsg_cpu_model.spm_op(CMD_ERASE, BAD, 4'hF);
      #1 check({flash_erase, cpu_halt}, 2'h0);
      setlk(2'h3, 2'h1, 1'h0);
      i_fsg_cpu_model.spm_op(CMD_WRITE, BAD, 4'hF);
      #1 check({flash_write, cpu_halt}, 2'h3);
      halt_len();
      setlk(2'h3, 2'h3, 1'h0);
      i_fsg_cpu_model.spm_op(CMD_LOCK_SET, 14'h0, 4'hE);
      rd(REG_LOCK, 32'hE);
      bus(1'h1, REG_LOCK, 32'hD);
      rd(REG_LOCK, 32'hC);
      setlk(2'h3, 2'h3, 1'h0);
      rd(REG_LOCK, 32'hF);
      @(posedge sys_clk);
      boot_size_fuses <= 2'h0;
      i_fsg_cpu_model.goto(14'h3810);
      i_fsg_cpu_model.spm_op(CMD_ERASE, AAD, 4'hF);
      #1 check({flash_erase, cpu_halt, region_busy_flag}, 3'h5);
      @(posedge sys_clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge sys_clk);
      check({region_busy_flag, avs_waitrequest}, 2'h1);
      reset_n <= 1'h1;
      rd(REG_STATUS, 32'hF0);
      tally_and_finish();
   end
endmodule
